// >>> core/fpec_defs.vh
// Constants for the flash program/erase control register block
`ifndef FPEC_DEFS_VH
`define FPEC_DEFS_VH

// Register byte addresses (APB, one aligned word each)
`define FPEC_ADDR_MODE_CTRL 8'h00
`define FPEC_ADDR_SETUP_ERR 8'h04
`define FPEC_ADDR_SYS_CTRL2 8'h08
`define FPEC_ADDR_WIDTH 8

// Mode control register fields
`define FPEC_MC_PIN 7
`define FPEC_MC_SWE 6
`define FPEC_MC_EV 3
`define FPEC_MC_PV 2
`define FPEC_MC_ERASE 1
`define FPEC_MC_PROG 0

// Setup and error register fields
`define FPEC_SE_FAULT 7
`define FPEC_SE_WSU 1
`define FPEC_SE_PSU 0

// Second system control field
`define FPEC_SC_WINDOW 0

// Reset and blanked values
`define FPEC_BYTE_ZERO 8'h00
`define FPEC_MC_RESET_PIN_HIGH 8'h80
`define FPEC_WORD_ZERO 32'h00000000

// Byte access takes two bus states: one wait state before pready
`define FPEC_WAIT_STATES 1'b1

`endif

// >>> core/fpec_mode_bit.v
// One gated writable mode bit with standby clear
`timescale 1ns/100ps
`default_nettype none

module fpec_mode_bit (
	input wire pclk,
	input wire presetn,
	// Synchronous clear (standby, protect)
	input wire clr,
	// Write strobe for this register
	input wire wr,
	// Enable condition for this bit
	input wire allow,
	// Write data for this bit
	input wire wdata,
	// Stored bit
	output reg bit_q
);

	// Next value of the bit
	reg bit_d;

	// Blocked writes keep old value, clear has priority
	always @* begin
		bit_d = bit_q;
		if (clr) begin
			bit_d = 1'b0;
		end else if (wr && allow) begin
			bit_d = wdata;
		end
	end

	// Storage, cleared asynchronously by reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_q <= 1'b0;
		end else begin
			bit_q <= bit_d;
		end
	end

endmodule

`default_nettype wire

// >>> core/fpec_top.v
// Flash program/erase control and status registers behind APB
`timescale 1ns/100ps
`default_nettype none
`include "fpec_defs.vh"

// Summary of operation
// - Bit 7 mirrors write-protect pin, read-only
// - Enable bit writable only while pin high
// - Verify bits need pin and enable set
// - Erase bit needs pin, enable, erase setup
// - Program bit needs pin, enable, program setup
// - Mode reg resets to 00; bit 7 takes the pin one clock later
// - Flash disabled: mode reads zero, ignores writes
// - Bits 5 and 4 read zero
// - Program: enable, then setup, then program
// - Erase: enable, then setup, then erase
// - Setup register resets zero, fault read-only
// - Setup bits cleared in standby or protect
// - Flash disabled: setup register reads zero
// - Error sets fault flag, forcing error protect
// - Fault cleared only by reset or hardware standby
// - Mode and setup registers visible only with window select
// - Byte access, two states each
module fpec_top (
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	// Write-protect pin level (high allows programming)
	input wire write_protect_pin,
	// Flash disabled by operating mode
	input wire flash_disabled,
	// Hardware standby request, level
	input wire hw_standby,
	// Software standby, level
	input wire sw_standby,
	// Program/erase error event, one-cycle pulse
	input wire flash_error,
	// Mode outputs to the flash array
	output wire program_mode,
	output wire erase_mode,
	output wire program_verify_mode,
	output wire erase_verify_mode,
	// Error-protect state to the flash array
	output wire error_protect
);

	// Wait counter for the two-state access
	reg wait_q;
	reg wait_d;
	// Fault flag
	reg fault_q;
	reg fault_d;
	// Register window select in second system control
	reg window_q;
	reg window_d;
	// Pin level one clock late, for the bit 7 image
	reg pin_cap_q;
	// Read word staged for the completing access cycle
	reg [31:0] prdata_d;

	// Stored mode bits
	// Each one comes from its own gated bit cell
	wire swe_q;
	wire ev_q;
	wire pv_q;
	wire erase_q;
	wire prog_q;
	wire wsu_q;
	wire psu_q;

	// Decoded strobes and gating conditions
	wire access;
	wire wr_done;
	wire addr_ok;
	wire sel_mc;
	wire sel_se;
	wire sel_sc;
	wire lane0;
	wire wr_mc;
	wire wr_se;
	wire standby_any;
	wire mc_clr;
	wire se_clr;
	wire hw_protect;
	wire sw_protect;
	wire allow_swe;
	wire allow_verify;
	wire allow_erase;
	wire allow_prog;
	wire allow_setup;
	wire [7:0] mc_byte;
	wire [7:0] se_byte;
	wire [7:0] sc_byte;

	// Access phase of an APB transfer
	assign access = psel && penable;
	assign pready = access && !wait_q;
	// Writes commit only at the completing edge
	assign wr_done = access && pready && pwrite;

	// Address decode, word aligned
	// Aliases with upper bits set answer with an error
	assign addr_ok = (paddr[1:0] == 2'b00)
		&& (paddr[31:`FPEC_ADDR_WIDTH] == 0);
	assign sel_mc = addr_ok && window_q
		&& (paddr[`FPEC_ADDR_WIDTH-1:0] == `FPEC_ADDR_MODE_CTRL);
	assign sel_se = addr_ok && window_q
		&& (paddr[`FPEC_ADDR_WIDTH-1:0] == `FPEC_ADDR_SETUP_ERR);
	// Second system control stays visible to reopen the window
	assign sel_sc = addr_ok
		&& (paddr[`FPEC_ADDR_WIDTH-1:0] == `FPEC_ADDR_SYS_CTRL2);
	// Unmapped or hidden addresses answer with an error
	assign pslverr = pready && !(sel_mc || sel_se || sel_sc);

	// byte access only, low lane carries data
	// A write without lane 0 changes nothing
	assign lane0 = pstrb[0];
	assign wr_mc = wr_done && sel_mc && lane0 && !flash_disabled;
	assign wr_se = wr_done && sel_se && lane0 && !flash_disabled;

	// mode register cleared by both standby modes
	// Levels: bits stay clear while standby lasts
	assign standby_any = hw_standby || sw_standby;
	assign mc_clr = standby_any;
	// Protect states: pin low, enable bit clear, or error
	assign hw_protect = !write_protect_pin;
	assign sw_protect = !swe_q;
	// setup bits cleared in standby and protect
	// Error protect drops setup too; re-arm after hardware standby
	assign se_clr = standby_any || hw_protect || sw_protect || fault_q;

	// enable bit needs the pin high
	assign allow_swe = write_protect_pin;
	// verify bits need pin and enable
	assign allow_verify = write_protect_pin && swe_q;
	assign allow_erase = write_protect_pin && swe_q && wsu_q && !fault_q;
	assign allow_prog = write_protect_pin && swe_q && psu_q && !fault_q;
	// Setup bits only take while enable is set
	assign allow_setup = write_protect_pin && swe_q;

	// each bit gated on its own, others still update
	// enable bit, pin low clears it
	fpec_mode_bit u_swe (
		.pclk(pclk),
		.presetn(presetn),
		.clr(mc_clr || hw_protect),
		.wr(wr_mc),
		.allow(allow_swe),
		.wdata(pwdata[`FPEC_MC_SWE]),
		.bit_q(swe_q)
	);

	fpec_mode_bit u_ev (
		.pclk(pclk),
		.presetn(presetn),
		.clr(mc_clr || hw_protect),
		.wr(wr_mc),
		.allow(allow_verify),
		.wdata(pwdata[`FPEC_MC_EV]),
		.bit_q(ev_q)
	);

	fpec_mode_bit u_pv (
		.pclk(pclk),
		.presetn(presetn),
		.clr(mc_clr || hw_protect),
		.wr(wr_mc),
		.allow(allow_verify),
		.wdata(pwdata[`FPEC_MC_PV]),
		.bit_q(pv_q)
	);

	// Error protect also drops erase and program
	// erase bit, needs erase setup
	fpec_mode_bit u_erase (
		.pclk(pclk),
		.presetn(presetn),
		.clr(mc_clr || hw_protect || fault_q),
		.wr(wr_mc),
		.allow(allow_erase),
		.wdata(pwdata[`FPEC_MC_ERASE]),
		.bit_q(erase_q)
	);

	fpec_mode_bit u_prog (
		.pclk(pclk),
		.presetn(presetn),
		.clr(mc_clr || hw_protect || fault_q),
		.wr(wr_mc),
		.allow(allow_prog),
		.wdata(pwdata[`FPEC_MC_PROG]),
		.bit_q(prog_q)
	);

	// setup bits read/write, reset to zero
	fpec_mode_bit u_wsu (
		.pclk(pclk),
		.presetn(presetn),
		.clr(se_clr),
		.wr(wr_se),
		.allow(allow_setup),
		.wdata(pwdata[`FPEC_SE_WSU]),
		.bit_q(wsu_q)
	);

	fpec_mode_bit u_psu (
		.pclk(pclk),
		.presetn(presetn),
		.clr(se_clr),
		.wr(wr_se),
		.allow(allow_setup),
		.wdata(pwdata[`FPEC_SE_PSU]),
		.bit_q(psu_q)
	);

	// Wait state: first access cycle stalls, second completes
	always @* begin
		wait_d = 1'b0;
		// Setup cycle arms the stall
		if (psel && !penable) begin
			wait_d = `FPEC_WAIT_STATES;
		// Stalled access cycle releases it
		end else if (access && wait_q) begin
			wait_d = 1'b0;
		end
	end

	// Wait-state register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= wait_d;
		end
	end

	// Fault flag: error sets, only hardware standby clears
	always @* begin
		fault_d = fault_q;
		// Standby in the same cycle as an error loses
		// error sets the flag; set wins
		if (flash_error) begin
			fault_d = 1'b1;
		end else if (hw_standby) begin
			fault_d = 1'b0;
		end
	end

	// Window select: software-writable, reset to zero
	// Clearing it hides the flash registers at once
	always @* begin
		window_d = window_q;
		if (wr_done && sel_sc && lane0) begin
			window_d = pwdata[`FPEC_SC_WINDOW];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_q <= 1'b0;
			window_q <= 1'b0;
		end else begin
			fault_q <= fault_d;
			window_q <= window_d;
		end
	end

	// Pin level tracked each cycle; reset value is a constant
	// Bit 7 therefore lags the pin by one clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_cap_q <= 1'b0;
		end else begin
			pin_cap_q <= write_protect_pin;
		end
	end

	// Register images
	// bit 7 shows pin; bits 5:4 zero; 80/00
	assign mc_byte = {pin_cap_q, swe_q, 2'b00, ev_q, pv_q, erase_q, prog_q};
	// bits 6 to 2 read zero
	assign se_byte = {fault_q, 5'b00000, wsu_q, psu_q};
	assign sc_byte = {7'b0000000, window_q};

	// Read mux: hidden, disabled or unmapped reads give zero
	always @* begin
		prdata_d = prdata;
		// Load in the stalled cycle so the word stands while pready is high
		if (access && wait_q && !pwrite) begin
			if (sel_mc && !flash_disabled) begin
				prdata_d = {24'h000000, mc_byte};
			end else if (sel_se && !flash_disabled) begin
				prdata_d = {24'h000000, se_byte};
			end else if (sel_sc) begin
				prdata_d = {24'h000000, sc_byte};
			end else begin
				prdata_d = `FPEC_WORD_ZERO;
			end
		end
	end

	// Read data register, holds until the next read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `FPEC_WORD_ZERO;
		end else begin
			prdata <= prdata_d;
		end
	end

	// Mode outputs to the array, blocked by error protect
	assign program_mode = prog_q && !fault_q;
	assign erase_mode = erase_q && !fault_q;
	// Verify modes stay visible under error protect
	assign program_verify_mode = pv_q;
	assign erase_verify_mode = ev_q;
	assign error_protect = fault_q;

endmodule

`default_nettype wire

// >>> testbench/flash_program_erase_control_test.sv
// Directed bench for the flash control block
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_control_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, rdat;
	logic pin = 1, fdis = 0, hws = 0, sws = 0, ferr = 0, rerr, rdy = 0;
	logic [3:0] strb = 4'h1;
	wire logic pready, pslverr, pm, em, pvm, evm, ep;
	wire logic [31:0] prdata;
	int n_fail = 0, check_count = 0, cyc = 0;
	fpec_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .write_protect_pin(pin), .flash_disabled(fdis),
		.hw_standby(hws), .sw_standby(sws), .flash_error(ferr), .program_mode(pm),
		.erase_mode(em), .program_verify_mode(pvm), .erase_verify_mode(evm),
		.error_protect(ep));
	// 10 MHz clock
	always #50 pclk = ~pclk;
	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail = n_fail + 1;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	// One APB transfer, held until ready, then one idle edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		// Sample mid-cycle where the answer is settled, act on the rising edge
		do begin
			@(negedge pclk);
			rdy = pready;
			rdat = prdata;
			rerr = pslverr;
			@(posedge pclk);
		end while (rdy !== 1'b1);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		xfer(0, a, 8'h00);
		chk(rdat, {24'h0, e});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	initial begin
		wt(4);
		presetn <= 1;
		wt(1);
		xfer(1, 8'h08, 8'h01);
		rc(8'h00, 8'h80);
		rc(8'h04, 8'h00);
		xfer(1, 8'h04, 8'h01);
		rc(8'h04, 8'h00);
		$display("reset values done");
		xfer(1, 8'h00, 8'h40);
		rc(8'h00, 8'hC0);
		xfer(1, 8'h00, 8'h48);
		rc(8'h00, 8'hC8);
		chk({28'h0, pm, em, pvm, evm}, 32'h1);
		xfer(1, 8'h00, 8'h44);
		rc(8'h00, 8'hC4);
		chk({28'h0, pm, em, pvm, evm}, 32'h2);
		xfer(1, 8'h00, 8'h41);
		rc(8'h00, 8'hC0);
		xfer(1, 8'h04, 8'h01);
		xfer(1, 8'h00, 8'h41);
		rc(8'h00, 8'hC1);
		chk({28'h0, pm, em, pvm, evm}, 32'h8);
		xfer(1, 8'h00, 8'h40);
		xfer(1, 8'h04, 8'h00);
		xfer(1, 8'h00, 8'h42);
		rc(8'h00, 8'hC0);
		xfer(1, 8'h04, 8'h02);
		xfer(1, 8'h00, 8'h42);
		rc(8'h00, 8'hC2);
		chk({28'h0, pm, em, pvm, evm}, 32'h4);
		$display("mode entry done");
		ferr <= 1;
		wt(1);
		ferr <= 0;
		wt(1);
		rc(8'h04, 8'h80);
		chk({28'h0, pm, em, pvm, evm}, 32'h0);
		xfer(1, 8'h04, 8'h00);
		rc(8'h04, 8'h80);
		sws <= 1;
		wt(2);
		sws <= 0;
		wt(1);
		rc(8'h00, 8'h80);
		rc(8'h04, 8'h80);
		hws <= 1;
		wt(2);
		hws <= 0;
		wt(1);
		rc(8'h04, 8'h00);
		$display("fault and standby done");
		pin <= 0;
		wt(2);
		rc(8'h00, 8'h00);
		xfer(1, 8'h00, 8'h40);
		rc(8'h00, 8'h00);
		pin <= 1;
		fdis <= 1;
		wt(2);
		rc(8'h00, 8'h00);
		rc(8'h04, 8'h00);
		xfer(1, 8'h00, 8'h40);
		fdis <= 0;
		wt(1);
		rc(8'h00, 8'h80);
		strb <= 4'h0;
		xfer(1, 8'h00, 8'h40);
		strb <= 4'h1;
		rc(8'h00, 8'h80);
		chk({31'h0, rerr}, 32'h0);
		xfer(1, 8'h08, 8'h00);
		xfer(0, 8'h00, 8'h00);
		chk({31'h0, rerr}, 32'h1);
		$display("protect and window done");
		report_and_stop();
	end
endmodule
`default_nettype wire

// >>> testbench/fpec_monitor.sv
// Port checker for the flash control block
`timescale 1ns/100ps
`default_nettype none
module fpec_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic write_protect_pin,
	input wire logic flash_disabled,
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic flash_error,
	input wire logic program_mode,
	input wire logic erase_mode,
	input wire logic program_verify_mode,
	input wire logic erase_verify_mode,
	input wire logic error_protect
);
	// Any mode output active
	wire logic any_mode = program_mode | erase_mode | program_verify_mode | erase_verify_mode;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_late: assert property (psel && penable && !pready |=> pready)
		else $error("no ready in second access cycle");
	a_setup_idle: assert property (psel && !penable |-> !pready)
		else $error("ready during setup");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_err_sets: assert property (flash_error |=> error_protect)
		else $error("fault flag not set");
	a_fault_holds: assert property (error_protect && !hw_standby |=> error_protect)
		else $error("fault flag cleared early");
	a_fault_blocks: assert property (error_protect |-> !program_mode && !erase_mode)
		else $error("mode active under fault");
	a_pin_low: assert property (!write_protect_pin [*3] |-> !any_mode)
		else $error("mode active with pin low");
	a_standby_clr: assert property ((sw_standby || hw_standby) [*2] |-> !any_mode)
		else $error("mode active in standby");
	a_off_zero: assert property (psel && penable && pready && !pwrite && flash_disabled
		&& paddr[7:0] < 8'h08 |-> prdata == 32'h00000000)
		else $error("disabled read not zero");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits set");
endmodule
bind fpec_top fpec_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pready, .prdata, .pslverr, .write_protect_pin, .flash_disabled, .hw_standby,
	.sw_standby, .flash_error, .program_mode, .erase_mode, .program_verify_mode,
	.erase_verify_mode, .error_protect);
`default_nettype wire
